/* edge_sync.sv */
// edge_sync: two-flop synchroniser with rising-edge pulse
// assumes: input pin asynchronous to clock
`timescale 1ns/10ps
module edge_sync (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic pin,
   output logic      level,
   output logic      rise
);
   logic meta;
   logic sync;
   logic prev;
   logic next_rise;
   always_comb begin
      next_rise = sync & ~prev;
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
         rise <= 1'b0;
      end else begin
         meta <= pin;
         sync <= meta;
         prev <= sync;
         rise <= next_rise;
      end
   end
   assign level = prev;
endmodule : edge_sync

/* match_timer.sv */
// match_timer: 16-bit up-counter with compare match and interrupt
// assumes: register port master per house bus, pin asynchronous
//
// Notes on behaviour
// - one control register and one 16-bit compare; compare survives reset
// - three modes: timer, event counter, window
// - timer mode counts internal clock; match raises interrupt, clears count
// - after match counting resumes from zero automatically
// - gear clock in slow mode matches only upper 5 compare bits
// - 3-bit source select; 000-011 faster taps, 101 slow oscillator, 100 none
// - slow/sleep allow 000,001; 01x none; slow 100/110 fast clock, timer only
// - timer times oscillator warm-up leaving slow mode
// - event mode counts pin rising edges; match interrupts and clears
// - window mode counts internal clock only while pin high
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
module match_timer #(
   parameter int cnt_width = 16
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [3:0]  address,
   input  wire logic [31:0] write_data,
   input  wire logic        write_strobe,
   input  wire logic        read_strobe,
   input  wire logic        timer2_input_pin,
   output logic [31:0]      read_data,
   output logic             timer2_match_irq,
   output logic             irq
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [11:0]          timer2_control_reg;
   logic [11:0]          next_control;
   logic [cnt_width-1:0] timer2_compare_value;
   logic [cnt_width-1:0] next_compare;
   logic [cnt_width-1:0] count;
   logic [cnt_width-1:0] next_count;
   logic [1:0]           status;
   logic [1:0]           next_status;
   logic [31:0]          next_read_data;
   logic                 next_match_irq;
   logic                 next_irq;
   logic                 pin_level;
   logic                 pin_rise;
   logic                 tick;
   logic                 half_tick;
   logic                 fast_toggle;
   logic                 next_fast_toggle;
   logic [4:0]           tap;
   logic                 src_ok;
   logic                 gear;
   logic                 inc;
   logic                 hit;
   logic [cnt_width-1:0] cmp_mask;
   logic [2:0]           timer2_clock_select;
   logic [1:0]           mode;
   logic [1:0]           opm;
   logic                 run;
   logic                 mode_sel;
   logic                 prescaler_half_select;
   logic                 slow_divider_select;

   assign timer2_clock_select   = timer2_control_reg[timer2_pkg::ck_lsb +: 3];
   assign mode                  = timer2_control_reg[timer2_pkg::mode_lsb +: 2];
   assign run                   = timer2_control_reg[timer2_pkg::run_bit];
   assign prescaler_half_select = timer2_control_reg[timer2_pkg::half_bit];
   assign slow_divider_select   = timer2_control_reg[timer2_pkg::slowdiv_bit];
   assign opm                   = timer2_control_reg[timer2_pkg::opmode_lsb +: 2];
   assign mode_sel              = (mode != timer2_pkg::mode_none);

   // ----------------------------------------
   // pin input and prescaler
   // ----------------------------------------
   edge_sync u_sync (
      .clock (clock),
      .rst   (rst),
      .pin   (timer2_input_pin),
      .level (pin_level),
      .rise  (pin_rise)
   );

   prescaler u_pre (
      .clock (clock),
      .rst   (rst),
      .tap   (tap),
      .half  (prescaler_half_select & ~slow_divider_select),
      .tick  (tick)
   );

   // ----------------------------------------
   // source clock selection
   // ----------------------------------------
   always_comb begin
      tap    = 5'(timer2_pkg::tap_000);
      src_ok = 1'b1;
      gear   = 1'b0;
      half_tick = fast_toggle;
      next_fast_toggle = ~fast_toggle;
      if (opm == timer2_pkg::op_slow || opm == timer2_pkg::op_sleep) begin
         case (timer2_clock_select)
            3'b000: tap = 5'(timer2_pkg::tap_000);
            3'b001: tap = 5'(timer2_pkg::tap_001);
            3'b100,
            3'b110: begin
               gear   = (opm == timer2_pkg::op_slow);
               src_ok = gear && (mode == timer2_pkg::mode_timer);
            end
            default: src_ok = 1'b0;
         endcase
      end else begin
         case (timer2_clock_select)
            3'b000: tap = 5'(timer2_pkg::tap_000);
            3'b001: tap = 5'(timer2_pkg::tap_001);
            3'b010: tap = 5'(timer2_pkg::tap_010);
            3'b011: tap = 5'(timer2_pkg::tap_011);
            3'b101: tap = 5'(timer2_pkg::tap_slow);
            default: src_ok = 1'b0;
         endcase
      end
   end

   // ----------------------------------------
   // counter and match
   // ----------------------------------------
   always_comb begin
      // gear clock ignores low compare bits so upper byte write is enough
      cmp_mask = gear ? {{(cnt_width-timer2_pkg::slow_drop){1'b1}},
                         {timer2_pkg::slow_drop{1'b0}}}
                      : {cnt_width{1'b1}};
      inc = 1'b0;
      if (run && src_ok && mode_sel) begin
         case (mode)
            timer2_pkg::mode_timer: begin
               if (gear) begin
                  inc = (timer2_clock_select == 3'b100) ? 1'b1 : half_tick;
               end else begin
                  inc = tick;
               end
            end
            timer2_pkg::mode_event:  inc = pin_rise;
            timer2_pkg::mode_window: inc = tick & pin_level;
            default:                 inc = 1'b0;
         endcase
      end
      hit = inc && (((count + cnt_width'(1)) & cmp_mask)
                    == (timer2_compare_value & cmp_mask));
      if (!run) begin
         next_count = '0;
      end else if (hit) begin
         next_count = '0;
      end else if (inc) begin
         next_count = count + cnt_width'(1);
      end else begin
         next_count = count;
      end
      next_match_irq = hit;
   end

   // ----------------------------------------
   // register port and interrupt
   // ----------------------------------------
   always_comb begin
      next_control = timer2_control_reg;
      next_compare = timer2_compare_value;
      next_status  = status;
      if (write_strobe && address == timer2_pkg::ctrl_addr) begin
         next_control = write_data[11:0];
      end
      if (write_strobe && address == timer2_pkg::compare_addr) begin
         next_compare = write_data[cnt_width-1:0];
      end
      if (write_strobe && address == timer2_pkg::status_addr) begin
         next_status = status & ~write_data[1:0];
      end
      // set beats clear
      if (hit) begin
         next_status[timer2_pkg::st_match] = 1'b1;
         // warm-up done when the gear-clock match lands
         if (timer2_control_reg[timer2_pkg::warm_bit] && gear) begin
            next_status[timer2_pkg::st_warm] = 1'b1;
         end
      end
      next_irq = |next_status & ~timer2_control_reg[timer2_pkg::mask_bit];
      next_read_data = 32'h0000_0000;
      if (read_strobe) begin
         case (address)
            timer2_pkg::ctrl_addr:    next_read_data = {20'h00000, timer2_control_reg};
            timer2_pkg::compare_addr: next_read_data = 32'(timer2_compare_value);
            timer2_pkg::count_addr:   next_read_data = 32'(count);
            timer2_pkg::status_addr:  next_read_data = {30'h0, status};
            default:                  next_read_data = 32'h0000_0000;
         endcase
      end
   end

   // compare has no reset: it keeps its contents across reset
   always_ff @(posedge clock) begin
      timer2_compare_value <= next_compare;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         timer2_control_reg <= timer2_pkg::ctrl_reset;
         count              <= '0;
         status             <= 2'b00;
         read_data          <= 32'h0000_0000;
         timer2_match_irq   <= 1'b0;
         irq                <= 1'b0;
         fast_toggle        <= 1'b0;
      end else begin
         timer2_control_reg <= next_control;
         count              <= next_count;
         status             <= next_status;
         read_data          <= next_read_data;
         timer2_match_irq   <= next_match_irq;
         irq                <= next_irq;
         fast_toggle        <= next_fast_toggle;
      end
   end
endmodule : match_timer

/* match_timer_props.sv */
// checker: port-level properties of match_timer
// assumes: bound to every match_timer, control mirrored from writes
`timescale 1ns/10ps
module match_timer_props #(
   parameter int cnt_width = 16
) (
   input logic        clock,
   input logic        rst,
   input logic [3:0]  address,
   input logic [31:0] write_data,
   input logic        write_strobe,
   input logic        read_strobe,
   input logic        timer2_input_pin,
   input logic [31:0] read_data,
   input logic        timer2_match_irq,
   input logic        irq
);
   // ----------------------------------------
   // mirror of control, pin quiet counter
   // ----------------------------------------
   logic [11:0] ctrl_q;
   logic [3:0]  quiet;
   logic        pin_q;
   logic        wr_ctrl;
   assign wr_ctrl = write_strobe && address == timer2_pkg::ctrl_addr;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl_q <= 12'h000;
         quiet  <= 4'h0;
         pin_q  <= 1'b0;
      end else begin
         ctrl_q <= wr_ctrl ? write_data[11:0] : ctrl_q;
         pin_q  <= timer2_input_pin;
         // saturates so a long quiet spell never wraps
         quiet  <= (wr_ctrl || timer2_input_pin != pin_q) ? 4'h0 :
                   ((quiet == 4'hf) ? quiet : quiet + 4'h1);
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   AST_IRQ_PULSE: assert property (timer2_match_irq |=> !timer2_match_irq)
      else $error("match pulse longer than one cycle");
   AST_IRQ_RAISE: assert property (timer2_match_irq && !ctrl_q[11] |=> ##[0:1] irq)
      else $error("unmasked match did not raise irq");
   AST_IRQ_MASK: assert property (ctrl_q[11] [*3] |-> !irq)
      else $error("masked irq high");
   AST_RD_IDLE: assert property (!read_strobe |=> read_data == 32'h0)
      else $error("read data outside read cycle");
   AST_RD_CTRL: assert property (read_strobe && address == timer2_pkg::ctrl_addr
      |=> read_data == {20'h0, $past(ctrl_q)})
      else $error("control read back wrong");
   AST_UNMAPPED: assert property (read_strobe && address[1:0] != 2'b00 |=> read_data == 32'h0)
      else $error("unmapped read not zero");
   AST_STOPPED: assert property (!ctrl_q[5] [*3] |-> !timer2_match_irq)
      else $error("match while stopped");
   AST_MODE_OFF: assert property ((ctrl_q[4:3] == 2'b11) [*3] |-> !timer2_match_irq)
      else $error("match with no mode");
   AST_EVENT_QUIET: assert property (ctrl_q[4:3] == 2'b01 && quiet >= 4'ha
      |-> !timer2_match_irq)
      else $error("event match without pin edge");
   AST_WINDOW_LOW: assert property (ctrl_q[4:3] == 2'b10 && !timer2_input_pin && quiet >= 4'ha
      |-> !timer2_match_irq)
      else $error("window match with pin low");
endmodule : match_timer_props

bind match_timer match_timer_props #(.cnt_width(cnt_width)) u_match_timer_props (
   .clock(clock), .rst(rst), .address(address), .write_data(write_data),
   .write_strobe(write_strobe), .read_strobe(read_strobe),
   .timer2_input_pin(timer2_input_pin), .read_data(read_data),
   .timer2_match_irq(timer2_match_irq), .irq(irq));

/* prescaler.sv */
// prescaler: free divider giving one-cycle tick per selected tap
// assumes: tap index below width
`timescale 1ns/10ps
module prescaler #(
   parameter int width = timer2_pkg::div_bits
) (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic [4:0] tap,
   input  wire logic       half,
   output logic            tick
);
   logic [width-1:0] count;
   logic [width-1:0] next_count;
   logic [width-1:0] mask;
   logic             next_tick;
   logic [4:0]       eff;
   always_comb begin
      // half select doubles the period
      eff = half ? 5'(tap + 5'h1) : tap;
      mask = width'((1 << eff) - 1);
      next_count = count + width'(1);
      next_tick = ((count & mask) == mask);
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count <= '0;
         tick  <= 1'b0;
      end else begin
         count <= next_count;
         tick  <= next_tick;
      end
   end
endmodule : prescaler

/* pulse_source.sv */
// pulse_source: event or window pulses on the timer input pin
// assumes: start sampled on a rising clock edge
`timescale 1ns/10ps
module pulse_source (
   input logic       clock,
   input logic       start,
   input logic [7:0] count,
   input logic [7:0] width,
   output logic      pin,
   output logic      busy
);
   initial begin
      pin = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge clock);
         if (start) begin
            busy <= 1'b1;
            repeat (count) begin
               pin <= 1'b1;
               repeat (width) @(posedge clock);
               pin <= 1'b0;
               repeat (width) @(posedge clock);
            end
            busy <= 1'b0;
         end
      end
   end
endmodule : pulse_source

/* tb_match_timer.sv */
// tb_match_timer: self-checking bench for match_timer
// assumes: pulse_source drives the pin, checker bound
`timescale 1ns/10ps
module tb_match_timer;
   logic clock, rst, write_strobe, read_strobe, start, busy, pin, match, irq;
   logic [3:0]  address;
   logic [31:0] write_data, read_data;
   logic [7:0]  count, width;
   int error_cnt, n_checks, cyc, last, prev, nmatch, k;
   // ctrl, compare, period, status
   logic [15:0] rows [7][4] = '{'{16'h0023, 16'h0004, 16'd32, 16'h1},
      '{16'h0063, 16'h0004, 16'd64, 16'h1}, '{16'h0022, 16'h0002, 16'd512, 16'h1},
      '{16'h0025, 16'h0002, 16'd1024, 16'h1}, '{16'h0624, 16'h0fff, 16'd2048, 16'h3},
      '{16'h0226, 16'h0fff, 16'd4096, 16'h1}, '{16'h00e3, 16'h0004, 16'd32, 16'h1}};
   match_timer u_match_timer (.clock(clock), .rst(rst), .address(address),
      .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
      .timer2_input_pin(pin), .read_data(read_data), .timer2_match_irq(match), .irq(irq));
   pulse_source u_pulse_source (.clock(clock), .start(start), .count(count),
      .width(width), .pin(pin), .busy(busy));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (match) begin
         prev <= last;
         last <= cyc;
         nmatch <= nmatch + 1;
      end
      if (cyc == 60000) begin
         error_cnt++;
         end_sim();
      end
   end
   task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      address <= a;
      write_data <= d;
      write_strobe <= 1'b1;
      @(posedge clock);
      write_strobe <= 1'b0;
      @(posedge clock);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      address <= a;
      read_strobe <= 1'b1;
      @(posedge clock);
      read_strobe <= 1'b0;
      #1 check("read_data", read_data, exp);
      @(posedge clock);
   endtask : rd
   task automatic pulses(input logic [7:0] n, input logic [7:0] w);
      count <= n;
      width <= w;
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      @(posedge clock);
      while (busy) @(posedge clock);
      repeat (8) @(posedge clock);
   endtask : pulses
   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_sim
   initial begin
      {cyc, last, prev, nmatch, error_cnt, n_checks} = '0;
      {rst, write_strobe, read_strobe, start} = 4'b1000;
      {address, write_data, count, width} = '0;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      // periodic matches over source codes 010, 011, 100, 101 and 110
      for (int i = 0; i < 7; i++) begin
         wr(timer2_pkg::compare_addr, 32'(rows[i][1]));
         wr(timer2_pkg::ctrl_addr, 32'(rows[i][0]));
         k = nmatch;
         while (nmatch < k + 2) @(posedge clock);
         #1 check("period", 32'(last - prev), 32'(rows[i][2]));
         check("irq", 32'(irq), 32'h1);
         rd(timer2_pkg::status_addr, 32'(rows[i][3]));
         wr(timer2_pkg::ctrl_addr, 32'h0);
         wr(timer2_pkg::status_addr, 32'h3);
      end
      // compare survives a reset taken while the timer is stopped
      wr(timer2_pkg::compare_addr, 32'h1234);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1 check("irq", 32'(irq), 32'h0);
      check("match", 32'(match), 32'h0);
      rd(timer2_pkg::ctrl_addr, 32'h0);
      rd(timer2_pkg::compare_addr, 32'h1234);
      rd(4'h2, 32'h0);
      wr(timer2_pkg::ctrl_addr, 32'h3b);
      repeat (100) @(posedge clock);
      rd(timer2_pkg::count_addr, 32'h0);
      // slow and sleep refuse the codes they do not offer
      wr(timer2_pkg::ctrl_addr, 32'h223);
      repeat (100) @(posedge clock);
      rd(timer2_pkg::count_addr, 32'h0);
      wr(timer2_pkg::ctrl_addr, 32'h324);
      repeat (100) @(posedge clock);
      rd(timer2_pkg::count_addr, 32'h0);
      // event counting, masking, clearing
      wr(timer2_pkg::compare_addr, 32'h3);
      wr(timer2_pkg::ctrl_addr, 32'h28);
      k = nmatch;
      pulses(8'd3, 8'd8);
      check("matches", 32'(nmatch - k), 32'h1);
      rd(timer2_pkg::count_addr, 32'h0);
      pulses(8'd2, 8'd8);
      rd(timer2_pkg::count_addr, 32'h2);
      wr(timer2_pkg::ctrl_addr, 32'h828);
      #1 check("irq", 32'(irq), 32'h0);
      // hold the mask long enough for the masked-irq property to see it
      repeat (3) @(posedge clock);
      #1 check("irq", 32'(irq), 32'h0);
      wr(timer2_pkg::ctrl_addr, 32'h28);
      #1 check("irq", 32'(irq), 32'h1);
      wr(timer2_pkg::status_addr, 32'h1);
      rd(timer2_pkg::status_addr, 32'h0);
      // window gating by pin level
      wr(timer2_pkg::ctrl_addr, 32'h33);
      repeat (200) @(posedge clock);
      // pin low holds the count left over from the event test
      rd(timer2_pkg::count_addr, 32'h2);
      pulses(8'd1, 8'd60);
      rd(timer2_pkg::status_addr, 32'h1);
      end_sim();
   end
endmodule : tb_match_timer

/* timer2_pkg.sv */
// timer2_pkg: constants for the 16-bit match timer
// assumes: single 100 MHz clock, plain register port
package timer2_pkg;
   // ----------------------------------------
   // register map (byte offsets)
   // ----------------------------------------
   localparam logic [3:0] ctrl_addr     = 4'h0;
   localparam logic [3:0] compare_addr  = 4'h4;
   localparam logic [3:0] count_addr    = 4'h8;
   localparam logic [3:0] status_addr   = 4'hc;
   // ----------------------------------------
   // control field positions
   // ----------------------------------------
   localparam int ck_lsb     = 0;   // [2:0] clock select
   localparam int mode_lsb   = 3;   // [4:3] mode
   localparam int run_bit    = 5;
   localparam int half_bit   = 6;   // prescaler half select
   localparam int slowdiv_bit = 7;  // slow divider select
   localparam int opmode_lsb = 8;   // [9:8] operating mode
   localparam int warm_bit   = 10;  // warm-up request
   localparam int mask_bit   = 11;  // interrupt mask
   localparam logic [11:0] ctrl_reset = 12'h000;
   // ----------------------------------------
   // status bits
   // ----------------------------------------
   localparam int st_match = 0;
   localparam int st_warm  = 1;
   // ----------------------------------------
   // prescaler taps (divide exponent)
   // ----------------------------------------
   localparam int div_bits  = 24;
   localparam int tap_000   = 23;
   localparam int tap_001   = 13;
   localparam int tap_010   = 8;
   localparam int tap_011   = 3;
   localparam int tap_slow  = 9;   // low-frequency oscillator stand-in
   localparam int slow_drop = 11;  // compare bits ignored on gear clock
   typedef enum logic [1:0] {
      mode_timer  = 2'b00,
      mode_event  = 2'b01,
      mode_window = 2'b10,
      mode_none   = 2'b11
   } count_mode_t;
   typedef enum logic [1:0] {
      op_normal = 2'b00,
      op_idle   = 2'b01,
      op_slow   = 2'b10,
      op_sleep  = 2'b11
   } op_mode_t;
endpackage : timer2_pkg
